// [rtl/alt_pkg.sv]
// Overview of operation
// - Service flag bits clear on an AUX write of one, and bit 1 also on an accept or refuse write; zero leaves them.
// - Test request bit 1, content protect bit 2, monitor control bit 3, vendor bit 6; others read zero.
// - Lower adjust byte: lane 0 swing/emphasis, lane 1 swing/emphasis, two bits each.
// - Upper adjust byte has the same layout for lanes 2 and 3, reset zero.
// - Test kind bit 0 asks link training using requested rate and lanes.
// - Test kind bit 1 asks a test pattern, bit 2 an identification read test.
// - Bit 3 asks physical pattern on version 1.1; remaining upper bits read zero.
// - Requested rate byte holds 06h, 0Ah or 14h codes, read-only, reset zero.
// - Requested lanes in bits 4:0 as 1, 2 or 4; bits 7:5 read zero.
// - Writing one to accept bit with refuse bit zero clears test flag and starts test mode.
// - Writing one to refuse bit clears test flag; test does not start.
// - Acknowledge bit 2 marks checksum written; bits 7:3 read zero.
// - Power byte: 01 normal, 10 deep sleep; resets to 01h.
// - SMBus offers block and indexed block transfers only; no single byte write.
// - SMBus address A8h with strap low, AAh with strap high.
// - SMBus holds twenty registers; only two are writable by users.
// - Listener captures sink read data for adjust, test, rate and lane bytes.
// - Accepted test makes captured values override the normal link configuration.
package alt_pkg;

    localparam logic [19:0] AUX_BW = 20'h00100;
    localparam logic [19:0] AUX_LCNT = 20'h00101;
    localparam logic [19:0] AUX_LSET0 = 20'h00103;
    localparam logic [19:0] AUX_LSET3 = 20'h00106;
    localparam logic [19:0] AUX_SVC = 20'h00201;
    localparam logic [19:0] AUX_ADJ_LO = 20'h00206;
    localparam logic [19:0] AUX_ADJ_HI = 20'h00207;
    localparam logic [19:0] AUX_KIND = 20'h00218;
    localparam logic [19:0] AUX_RATE = 20'h00219;
    localparam logic [19:0] AUX_LANES = 20'h00220;
    localparam logic [19:0] AUX_ACK = 20'h00260;
    localparam logic [19:0] AUX_PWR = 20'h00600;

    localparam logic [4:0] SMB_BW = 5'h02;
    localparam logic [4:0] SMB_LCNT = 5'h03;
    localparam logic [4:0] SMB_LSET0 = 5'h04;
    localparam logic [4:0] SMB_LSET3 = 5'h07;
    localparam logic [4:0] SMB_SVC = 5'h09;
    localparam logic [4:0] SMB_ADJ_LO = 5'h0A;
    localparam logic [4:0] SMB_KIND = 5'h0C;
    localparam logic [4:0] SMB_RATE = 5'h0D;
    localparam logic [4:0] SMB_LANES = 5'h0E;
    localparam logic [4:0] SMB_ACK = 5'h0F;
    localparam logic [4:0] SMB_PWR = 5'h10;
    localparam logic [4:0] SMB_ADJ_HI = 5'h11;
    localparam logic [7:0] SMB_NREG = 8'h14;
    localparam logic [5:0] SMB_ADDR_HI = 6'h2A;

    localparam logic [7:0] SVC_MASK = 8'h4E;
    localparam int AUTO_BIT = 1;
    localparam logic [7:0] KIND_MASK_V11 = 8'h0F;
    localparam logic [7:0] KIND_MASK_V10 = 8'h07;
    localparam logic [7:0] LANES_MASK = 8'h1F;
    localparam logic [7:0] ACK_MASK = 8'h07;
    localparam logic [1:0] ACK_ACCEPT = 2'h1;
    localparam logic [1:0] PWR_NORMAL = 2'h1;
    localparam logic [1:0] PWR_DEEP = 2'h2;
    localparam logic [7:0] BW_RST = 8'h14;
    localparam logic [7:0] LCNT_RST = 8'h04;

    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_CMD, S_CNT, S_WDAT, S_DONE, S_ACK, S_TX, S_RACK
    } alt_smb_st_e;

    typedef enum logic {AUX_RD_DATA, AUX_WR_DATA} alt_aux_kind_e;

    typedef struct packed {
        logic valid;
        alt_aux_kind_e kind;
        logic [19:0] addr;
        logic [7:0] data;
    } alt_aux_evt_s;

    typedef struct packed {
        logic [7:0] rate;
        logic [7:0] lanes;
        logic [3:0][1:0] swing;
        logic [3:0][1:0] emph;
    } alt_link_cfg_s;

endpackage

// [rtl/alt_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module alt_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk, // Clock
    input wire logic rst_n, // Synchronous-domain reset copy
    input wire logic [W-1:0] d, // Asynchronous inputs
    output logic [W-1:0] q // Synchronised outputs
);
    logic [1:0][W-1:0] r, n;

    always_comb begin
        n = {r[0], d};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= {RST_VAL, RST_VAL};
        end else begin
            r <= n;
        end
    end

    assign q = r[1];
endmodule // alt_sync
`default_nettype wire

// [rtl/alt_lane_mux.sv]
`timescale 1ns/10ps
`default_nettype none
module alt_lane_mux #(
    parameter int LANES = 4
) (
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic override, // Sink test accepted
    input wire logic [15:0] adj, // Captured adjust bytes, upper:lower
    input wire logic [7:0] test_rate, // Captured rate
    input wire logic [7:0] test_lanes, // Captured lane count
    input wire logic [7:0] bw, // Normal rate
    input wire logic [7:0] lcnt, // Normal lane count
    input wire logic [3:0][7:0] lset, // Normal per-lane settings
    output alt_pkg::alt_link_cfg_s cfg // Buffer configuration
);
    import alt_pkg::*;

    if (LANES != 4) begin : g_chk
        $error("alt_lane_mux serves exactly four lanes");
    end

    alt_link_cfg_s r, n;

    always_comb begin
        n.rate = override ? test_rate : bw;
        n.lanes = override ? test_lanes : lcnt;
        for (int i = 0; i < LANES; i++) begin
            n.swing[i] = override ? adj[4*i +: 2] : lset[i][1:0];
            n.emph[i] = override ? adj[4*i+2 +: 2] : lset[i][4:3];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign cfg = r;
endmodule // alt_lane_mux
`default_nettype wire

// [rtl/alt_listener_regs.sv]
`timescale 1ns/10ps
`default_nettype none
module alt_listener_regs #(
    parameter bit PROTO_V11 = 1'b1
) (
    input wire logic ref_clk, // 200 MHz clock
    input wire logic rstn, // Power-on reset, active low
    input wire alt_pkg::alt_aux_evt_s aux_evt, // Snooped AUX byte
    input wire logic scl_pin, // SMBus clock
    input wire logic sda_pin, // SMBus data in
    output logic sda_out, // SMBus data out
    output logic sda_oe, // SMBus data drive enable
    input wire logic addr_strap, // SMBus address strap
    output alt_pkg::alt_link_cfg_s link_cfg, // Buffer configuration
    output logic test_override, // Sink test running
    output logic deep_sleep // Power-down requested
);
    import alt_pkg::*;

    typedef struct packed {
        alt_smb_st_e st;
        alt_smb_st_e after;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [4:0] idx;
        logic [7:0] cnt;
        logic ackp;
        logic drv;
        logic scl_q;
        logic sda_q;
        logic [7:0] svc;
        logic [7:0] adj_lo;
        logic [7:0] adj_hi;
        logic [7:0] kind;
        logic [7:0] rate;
        logic [7:0] lanes;
        logic [7:0] ack;
        logic [7:0] bw;
        logic [7:0] lcnt;
        logic [3:0][7:0] lset;
        logic [1:0] pwr;
    } alt_state_s;

    localparam logic [7:0] KIND_MASK = PROTO_V11 ? KIND_MASK_V11 : KIND_MASK_V10;
    localparam alt_state_s ST_RST = '{st: S_IDLE, after: S_IDLE, bitcnt: 4'h0, shreg: 8'h00,
        idx: 5'h00, cnt: 8'h00, ackp: 1'b0, drv: 1'b0, scl_q: 1'b1, sda_q: 1'b1, svc: 8'h00,
        adj_lo: 8'h00, adj_hi: 8'h00, kind: 8'h00, rate: 8'h00, lanes: 8'h00, ack: 8'h00,
        bw: BW_RST, lcnt: LCNT_RST, lset: '0, pwr: PWR_NORMAL};

    // ------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic rst_s_n;
    logic [2:0] pins_s;
    logic strap_s, scl_s, sda_s;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_s_n = rst_sync_r[1];

    alt_sync #(.W(3), .RST_VAL(3'b111)) alt_sync_i (
        .clk(ref_clk),
        .rst_n(rst_s_n),
        .d({addr_strap, scl_pin, sda_pin}),
        .q(pins_s)
    );
    assign {strap_s, scl_s, sda_s} = pins_s;

    // ------------------------------------------------------------
    // Register read map
    // ------------------------------------------------------------
    function automatic logic [7:0] reg_read(input alt_state_s s, input logic [4:0] i);
        logic [7:0] v;
        v = 8'h00;
        case (i)
            SMB_BW: v = s.bw;
            SMB_LCNT: v = s.lcnt;
            SMB_SVC: v = s.svc;
            SMB_ADJ_LO: v = s.adj_lo;
            SMB_ADJ_HI: v = s.adj_hi;
            SMB_KIND: v = s.kind;
            SMB_RATE: v = s.rate;
            SMB_LANES: v = s.lanes;
            SMB_ACK: v = s.ack;
            SMB_PWR: v = {6'h00, s.pwr};
            default: begin
                if (i >= SMB_LSET0 && i <= SMB_LSET3) begin
                    v = s.lset[2'(i - SMB_LSET0)];
                end
            end
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // State update
    // ------------------------------------------------------------
    alt_state_s r, n;
    logic [7:0] svc_set, svc_clr, byte_in;
    logic rise, fall, start, stop;

    assign rise = scl_s & ~r.scl_q;
    assign fall = ~scl_s & r.scl_q;
    assign start = scl_s & r.scl_q & r.sda_q & ~sda_s;
    assign stop = scl_s & r.scl_q & ~r.sda_q & sda_s;
    assign byte_in = {r.shreg[6:0], sda_s};

    always_comb begin
        n = r;
        svc_set = 8'h00;
        svc_clr = 8'h00;
        n.scl_q = scl_s;
        n.sda_q = sda_s;
        if (aux_evt.valid && aux_evt.kind == AUX_RD_DATA) begin
            case (aux_evt.addr)
                AUX_SVC: svc_set = aux_evt.data & SVC_MASK;
                AUX_ADJ_LO: n.adj_lo = aux_evt.data;
                AUX_ADJ_HI: n.adj_hi = aux_evt.data;
                AUX_KIND: if (r.svc[AUTO_BIT]) n.kind = aux_evt.data & KIND_MASK;
                AUX_RATE: if (r.svc[AUTO_BIT]) n.rate = aux_evt.data;
                AUX_LANES: if (r.svc[AUTO_BIT]) n.lanes = aux_evt.data & LANES_MASK;
                default: ;
            endcase
        end else if (aux_evt.valid) begin
            case (aux_evt.addr)
                AUX_SVC: svc_clr = aux_evt.data;
                AUX_ACK: begin
                    n.ack = aux_evt.data & ACK_MASK;
                    svc_clr[AUTO_BIT] = |aux_evt.data[1:0];
                end
                AUX_PWR: n.pwr = aux_evt.data[1:0];
                AUX_BW: n.bw = aux_evt.data;
                AUX_LCNT: n.lcnt = aux_evt.data;
                default: begin
                    if (aux_evt.addr >= AUX_LSET0 && aux_evt.addr <= AUX_LSET3) begin
                        n.lset[2'(aux_evt.addr - AUX_LSET0)] = aux_evt.data;
                    end
                end
            endcase
        end
        n.svc = (r.svc & ~svc_clr) | svc_set;

        if (start) begin
            n.st = S_ADDR;
            n.bitcnt = 4'h0;
            n.drv = 1'b0;
        end else if (stop) begin
            n.st = S_IDLE;
            n.drv = 1'b0;
        end else begin
            unique case (r.st)
                S_IDLE: ;
                S_ADDR, S_CMD, S_CNT, S_WDAT: begin
                    if (rise) begin
                        n.shreg = byte_in;
                        n.bitcnt = r.bitcnt + 4'h1;
                        if (r.bitcnt == 4'h7) begin
                            n.st = S_DONE;
                            n.ackp = 1'b1;
                            case (r.st)
                                S_ADDR: begin
                                    if (byte_in[7:1] == {SMB_ADDR_HI, strap_s}) begin
                                        if (byte_in[0]) begin
                                            n.after = S_TX;
                                            n.shreg = (r.idx < SMB_NREG) ? SMB_NREG - {3'h0, r.idx} : 8'h00;
                                        end else begin
                                            n.after = S_CMD;
                                        end
                                    end else begin
                                        n.ackp = 1'b0;
                                    end
                                end
                                S_CMD: begin
                                    n.idx = byte_in[4:0];
                                    n.after = S_CNT;
                                end
                                S_CNT: begin
                                    n.cnt = byte_in;
                                    n.after = S_WDAT;
                                end
                                default: begin
                                    if (r.cnt != 8'h00) begin
                                        n.cnt = r.cnt - 8'h01;
                                        n.idx = r.idx + 5'h01;
                                        n.after = S_WDAT;
                                        if (r.idx == SMB_ACK) n.ack = byte_in & ACK_MASK;
                                        if (r.idx == SMB_PWR) n.pwr = byte_in[1:0];
                                    end else begin
                                        n.ackp = 1'b0;
                                    end
                                end
                            endcase
                        end
                    end
                end
                S_DONE: begin
                    if (fall) begin
                        n.drv = r.ackp;
                        n.st = r.ackp ? S_ACK : S_IDLE;
                    end
                end
                S_ACK: begin
                    if (fall) begin
                        n.st = r.after;
                        n.bitcnt = (r.after == S_TX) ? 4'h1 : 4'h0;
                        n.drv = (r.after == S_TX) ? ~r.shreg[7] : 1'b0;
                    end
                end
                S_TX: begin
                    if (fall) begin
                        if (r.bitcnt == 4'h8) begin
                            n.drv = 1'b0;
                            n.st = S_RACK;
                        end else begin
                            n.shreg = {r.shreg[6:0], 1'b0};
                            n.drv = ~r.shreg[6];
                            n.bitcnt = r.bitcnt + 4'h1;
                        end
                    end
                end
                S_RACK: begin
                    if (rise) begin
                        if (!sda_s) begin
                            n.shreg = reg_read(r, r.idx);
                            n.idx = r.idx + 5'h01;
                            n.after = S_TX;
                            n.st = S_ACK;
                        end else begin
                            n.st = S_IDLE;
                        end
                    end
                end
                default: n.st = S_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            r <= ST_RST;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign sda_out = 1'b0;
    assign sda_oe = r.drv;
    assign test_override = (r.ack[1:0] == ACK_ACCEPT);
    assign deep_sleep = (r.pwr == PWR_DEEP);

    alt_lane_mux #(.LANES(4)) alt_lane_mux_i (
        .clk(ref_clk),
        .rst_n(rst_s_n),
        .override(test_override),
        .adj({r.adj_hi, r.adj_lo}),
        .test_rate(r.rate),
        .test_lanes(r.lanes),
        .bw(r.bw),
        .lcnt(r.lcnt),
        .lset(r.lset),
        .cfg(link_cfg)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_s_n);

    logic aux_wr_svc, aux_wr_ack, aux_rd_rate, aux_wr_pwr;
    assign aux_wr_svc = aux_evt.valid && aux_evt.kind == AUX_WR_DATA && aux_evt.addr == AUX_SVC;
    assign aux_wr_ack = aux_evt.valid && aux_evt.kind == AUX_WR_DATA && aux_evt.addr == AUX_ACK;
    assign aux_rd_rate = aux_evt.valid && aux_evt.kind == AUX_RD_DATA && aux_evt.addr == AUX_RATE;
    assign aux_wr_pwr = aux_evt.valid && aux_evt.kind == AUX_WR_DATA && aux_evt.addr == AUX_PWR;

    a_svc_rsvd: assert property ((r.svc & ~SVC_MASK) == 8'h00) else $error("service reserved bit set");
    a_w1c_clear: assert property (aux_wr_svc |=> (r.svc & $past(aux_evt.data)) == 8'h00)
        else $error("written one did not clear flag");
    a_w0_keep: assert property (aux_wr_svc |=>
        (r.svc & ~$past(aux_evt.data)) == ($past(r.svc) & ~$past(aux_evt.data)))
        else $error("written zero changed flag");
    a_ack_clears: assert property (aux_wr_ack && aux_evt.data[1:0] != 2'b00 |=> !r.svc[AUTO_BIT])
        else $error("acknowledge did not clear test flag");
    a_kind_rsvd: assert property ((r.kind & ~KIND_MASK) == 8'h00) else $error("test kind reserved bit set");
    a_lanes_rsvd: assert property (r.lanes[7:5] == 3'h0) else $error("lane count reserved bit set");
    a_ack_rsvd: assert property (r.ack[7:3] == 5'h00) else $error("acknowledge reserved bit set");
    a_rate_cap: assert property (aux_rd_rate && r.svc[AUTO_BIT] |=> r.rate == $past(aux_evt.data))
        else $error("requested rate not captured");
    // Mux register output follows the bank values one edge later
    a_override_cfg: assert property (rst_s_n && test_override && $stable(r.rate) |=>
        link_cfg.rate == $past(r.rate))
        else $error("override rate not applied");
    a_normal_cfg: assert property (rst_s_n && !test_override && $stable(r.bw) |=>
        link_cfg.rate == $past(r.bw))
        else $error("normal rate not applied");
    a_stop_release: assert property (stop |=> !sda_oe) else $error("data held after stop");
    a_sleep_code: assert property (aux_wr_pwr |=>
        deep_sleep == (($past(aux_evt.data) & 8'h03) == {6'h00, PWR_DEEP}))
        else $error("deep sleep decode wrong");

    c_override: cover property (aux_wr_ack && aux_evt.data[1:0] == ACK_ACCEPT ##1 test_override);
    c_flag_set: cover property (!r.svc[AUTO_BIT] ##1 r.svc[AUTO_BIT]);
    c_smb_write: cover property (r.st == S_WDAT && n.st == S_DONE && n.ackp);
    c_smb_read: cover property (r.st == S_RACK && n.st == S_ACK);
    c_sleep: cover property (!deep_sleep ##1 deep_sleep);
endmodule // alt_listener_regs
`default_nettype wire

// [bench/alt_smb_host.sv]
`timescale 1ns/10ps
`default_nettype none
module alt_smb_host (
    input wire logic ref_clk, // Clock
    input wire logic sda_in, // Resolved SDA level
    output logic scl, // SMBus clock
    output logic sda_low // Host pulls SDA low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // ----------------------------------------
    // Bus cycle helpers
    // ----------------------------------------
    task automatic hw(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Start or repeated start
    task automatic start();
        sda_low = 1'b0;
        hw(10);
        scl = 1'b1;
        hw(10);
        sda_low = 1'b1;
        hw(10);
        scl = 1'b0;
        hw(5);
    endtask
    task automatic stop();
        sda_low = 1'b1;
        hw(10);
        scl = 1'b1;
        hw(10);
        sda_low = 1'b0;
        hw(10);
    endtask
    // Data set while SCL low, sampled while high
    task automatic bit_io(input logic b, output logic s);
        sda_low = ~b;
        hw(10);
        scl = 1'b1;
        hw(10);
        s = sda_in;
        scl = 1'b0;
        hw(5);
    endtask
    // Byte out MSB first, returns slave ACK
    task automatic wr(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(v[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    // Byte in, then ACK or NACK on last
    task automatic rd(input logic last, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            v[i] = s;
        end
        bit_io(last, s);
    endtask
endmodule // alt_smb_host
`default_nettype wire

// [bench/tb_aux_listener_test_regs.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_aux_listener_test_regs;
    import alt_pkg::*;
    logic ref_clk, rstn, strap, sda_low, scl, sda_out, sda_oe, test_override, deep_sleep;
    alt_aux_evt_s aux_evt;
    alt_link_cfg_s link_cfg;
    int bad_count, check_count;
    // Open drain with pull-up
    wire logic sda = ~(sda_low | (sda_oe & ~sda_out));
    alt_listener_regs #(.PROTO_V11(1'b1)) alt_listener_regs_i (.ref_clk(ref_clk), .rstn(rstn),
        .aux_evt(aux_evt), .scl_pin(scl), .sda_pin(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_strap(strap), .link_cfg(link_cfg), .test_override(test_override), .deep_sleep(deep_sleep));
    alt_smb_host alt_smb_host_i (.ref_clk(ref_clk), .sda_in(sda), .scl(scl), .sda_low(sda_low));
    always #2.5 ref_clk = ~ref_clk;
    // ----------------------------------------
    // Checking and access tasks
    // ----------------------------------------
    task automatic end_of_test();
        if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic aux(input alt_aux_kind_e k, input logic [19:0] a, input logic [7:0] d);
        aux_evt = '{1'b1, k, a, d};
        @(posedge ref_clk);
        #1;
        aux_evt.valid = 1'b0;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic sread(input logic [4:0] idx, input logic [7:0] e[$]);
        logic a;
        logic [7:0] v;
        alt_smb_host_i.start();
        alt_smb_host_i.wr({6'h2A, strap, 1'b0}, a);
        alt_smb_host_i.wr({3'h0, idx}, a);
        alt_smb_host_i.start();
        alt_smb_host_i.wr({6'h2A, strap, 1'b1}, a);
        chk("read addr ack", 1, a);
        alt_smb_host_i.rd(1'b0, v);
        chk("count", 8'h14 - idx, v);
        foreach (e[i]) begin
            alt_smb_host_i.rd(i == e.size() - 1, v);
            chk("smbus data", e[i], v);
        end
        alt_smb_host_i.stop();
    endtask
    task automatic swrite(input logic [7:0] adr, input logic [4:0] idx, input logic [7:0] d[$], input logic blk);
        logic a;
        alt_smb_host_i.start();
        alt_smb_host_i.wr(adr, a);
        chk("write addr ack", adr[7:1] == {6'h2A, strap}, a);
        if (a) begin
            alt_smb_host_i.wr({3'h0, idx}, a);
            if (blk) alt_smb_host_i.wr(8'(d.size()), a);
            foreach (d[i]) alt_smb_host_i.wr(d[i], a);
        end
        alt_smb_host_i.stop();
    endtask
    initial begin
        repeat (90000) @(posedge ref_clk);
        bad_count++;
        end_of_test();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        rstn = 1'b0;
        strap = 1'b0;
        aux_evt = '0;
        bad_count = 0;
        check_count = 0;
        repeat (20) @(posedge ref_clk);
        #1;
        rstn = 1'b1;
        repeat (10) @(posedge ref_clk);
        #1;
        chk("base link_cfg", 32'h1404_0000, link_cfg);
        sread(5'h09, {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00});
        // Sink replies seen by the source after the flag is set
        aux(AUX_RD_DATA, 20'h00201, 8'hFF);
        aux(AUX_RD_DATA, 20'h00206, 8'hE4);
        aux(AUX_RD_DATA, 20'h00207, 8'h1B);
        aux(AUX_RD_DATA, 20'h00218, 8'hFF);
        aux(AUX_RD_DATA, 20'h00219, 8'h0A);
        aux(AUX_RD_DATA, 20'h00220, 8'hE4);
        sread(5'h09, {8'h4E, 8'hE4, 8'h00, 8'h0F, 8'h0A, 8'h04, 8'h00, 8'h01, 8'h1B});
        aux(AUX_WR_DATA, 20'h00201, 8'h08);
        aux(AUX_WR_DATA, 20'h00201, 8'h00);
        aux(AUX_WR_DATA, 20'h00260, 8'h01);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("accept override", 1, test_override);
        chk("test link_cfg", 32'h0A04_782D, link_cfg);
        sread(5'h09, {8'h44});
        aux(AUX_RD_DATA, 20'h00201, 8'h02);
        aux(AUX_WR_DATA, 20'h00260, 8'h02);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("refuse override", 0, test_override);
        chk("refused link_cfg", 32'h1404_0000, link_cfg);
        aux(AUX_WR_DATA, 20'h00260, 8'h04);
        sread(5'h09, {8'h44, 8'hE4, 8'h00, 8'h0F, 8'h0A, 8'h04, 8'h04});
        swrite(8'hA8, 5'h0F, {8'hFF}, 1'b1);
        sread(5'h0F, {8'h07, 8'h01});
        chk("illegal ack code", 0, test_override);
        aux(AUX_WR_DATA, 20'h00600, 8'h02);
        chk("aux deep sleep", 1, deep_sleep);
        swrite(8'hA8, 5'h10, {8'h02}, 1'b1);
        chk("deep sleep on", 1, deep_sleep);
        swrite(8'hA8, 5'h10, {8'h01}, 1'b0);
        chk("single byte ignored", 1, deep_sleep);
        swrite(8'hA8, 5'h10, {8'h01}, 1'b1);
        chk("deep sleep off", 0, deep_sleep);
        strap = 1'b1;
        swrite(8'hA8, 5'h10, {8'h02}, 1'b1);
        chk("wrong addr ignored", 0, deep_sleep);
        swrite(8'hAA, 5'h10, {8'h02}, 1'b1);
        chk("strap high addr", 1, deep_sleep);
        end_of_test();
    end
endmodule // tb_aux_listener_test_regs
`default_nettype wire
